// File: include/opt_regs_pkg.sv
// constants and carrier types for the option register bank
package opt_regs_pkg;
	// command codes of the three registers
	localparam logic [7:0] CODE_REV = 8'hae;
	localparam logic [7:0] CODE_SCRATCH = 8'hd0;
	localparam logic [7:0] CODE_OPTIONS = 8'he5;
	// values after reset
	localparam logic [15:0] SCRATCH_RESET = 16'h0000;
	localparam logic [15:0] OPTIONS_RESET = 16'h00c7;
	// write masks and the mask of option bits kept in the non-volatile store
	localparam logic [15:0] SCRATCH_WR_MASK = 16'h00ff;
	localparam logic [15:0] OPTIONS_WR_MASK = 16'h01ff;
	localparam logic [15:0] OPTIONS_NVM_MASK = 16'h01e7;
	// field positions in the option word
	localparam int FORCED_THR_BIT = 0;
	localparam int AUTO_THR_BIT = 1;
	localparam int CONV_EN_BIT = 2;
	localparam int VONLY_BIT = 3;
	localparam int OVERRIDE_BIT = 4;
	localparam int AVG_LSB = 5;
	localparam int AUTO_ARA_BIT = 7;
	localparam int SS_DIS_BIT = 8;
	// block read byte count and averaging encodings
	localparam logic [7:0] BLOCK_COUNT = 8'h02;
	localparam logic [1:0] AVG_16 = 2'h0;
	localparam logic [1:0] AVG_BYPASS = 2'h1;
	localparam logic [1:0] AVG_8 = 2'h2;
	localparam logic [1:0] AVG_32 = 2'h3;
	localparam logic [5:0] DEPTH_16 = 6'h10;
	localparam logic [5:0] DEPTH_8 = 6'h08;
	localparam logic [5:0] DEPTH_32 = 6'h20;
	localparam logic [5:0] DEPTH_ONE = 6'h01;

	// one command from the protocol engine
	typedef struct packed {
		logic wr_word;
		logic rd_start;
		logic byte_len;
		logic [7:0] code;
		logic [15:0] wdata;
	} cmd_t;

	// image exchanged with the non-volatile store
	typedef struct packed {
		logic [7:0] scratch;
		logic [15:0] options;
	} nvm_image_t;

	// settings handed to the measurement path
	typedef struct packed {
		logic conv_en;
		logic vout_upd;
		logic iout_upd;
		logic temp_upd;
		logic fast_vout;
		logic avg_bypass;
		logic [5:0] avg_depth;
	} meas_ctl_t;
endpackage

// File: hw/pmbus_option_registers.sv
// option, scratch and revision registers of the management port
`timescale 1ns/100ps
module pmbus_option_registers #(
	parameter logic [15:0] SILICON_REV = 16'h0001, // arbitrary value
	parameter int FAULTS = 8
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire opt_regs_pkg::cmd_t cmd_i,
	input wire logic rd_pop_i,
	input wire logic store_all_i,
	input wire logic nvm_restore_i,
	input wire opt_regs_pkg::nvm_image_t nvm_image_i,
	input wire logic bus_detect_cmp_i,
	input wire logic preset_voltage_pin_used_i,
	input wire logic invalid_seen_i,
	input wire logic ara_answered_i,
	input wire logic [FAULTS-1:0] fault_active_i,
	input wire logic [FAULTS-1:0] fault_unmask_i,
	output logic ack_o,
	output logic nack_o,
	output logic [7:0] rd_byte_o,
	output logic rd_valid_o,
	output logic rd_last_o,
	output logic nvm_save_o,
	output opt_regs_pkg::nvm_image_t nvm_image_o,
	output logic thr_1v8_o,
	output opt_regs_pkg::meas_ctl_t meas_ctl_o,
	output logic write_check_override_o,
	output logic invalid_flag_set_o,
	output logic soft_start_detect_disable_o,
	output logic [FAULTS-1:0] fault_mask_o
);
	import opt_regs_pkg::*;

	typedef struct packed {
		logic [15:0] scratch;
		logic [15:0] options;
		logic [23:0] rd_buf;
		logic [1:0] rd_cnt;
		logic rd_valid;
		logic rd_last;
		logic ack;
		logic nack;
		logic save;
		nvm_image_t image;
		logic cmp_s1;
		logic cmp_s2;
		logic cmp_s3;
		logic cmp_stable;
		logic thr_1v8;
		meas_ctl_t meas;
		logic inv_set;
		logic [FAULTS-1:0] fmask;
	} state_t;

	state_t state_reg;
	state_t state_next;
	logic hit_rev;
	logic hit_scratch;
	logic hit_options;
	logic mapped;
	logic [1:0] avg_sel;

	assign hit_rev = cmd_i.code == CODE_REV;
	assign hit_scratch = cmd_i.code == CODE_SCRATCH;
	assign hit_options = cmd_i.code == CODE_OPTIONS;
	assign mapped = hit_rev | hit_scratch | hit_options;
	assign avg_sel = state_reg.options[AVG_LSB+:2];

	// next state of every register in the bank
	always_comb begin
		state_next = state_reg;
		state_next.ack = 1'b0;
		state_next.nack = 1'b0;
		state_next.save = 1'b0;
		// byte transfers and unknown codes are refused outright
		if (cmd_i.wr_word || cmd_i.rd_start) begin
			if (cmd_i.byte_len || !mapped) begin
				state_next.nack = 1'b1;
			end else begin
				state_next.ack = 1'b1;
			end
		end
		// word writes; the revision word takes no write
		// revision write ignored
		if (cmd_i.wr_word && !cmd_i.byte_len) begin
			if (hit_scratch) begin
				state_next.scratch = cmd_i.wdata & SCRATCH_WR_MASK;
			end
			if (hit_options) begin
				state_next.options = cmd_i.wdata & OPTIONS_WR_MASK;
			end
		end
		// restore loads saved fields, volatile bits keep their value
		if (nvm_restore_i) begin
			state_next.scratch = {8'h00, nvm_image_i.scratch};
			state_next.options = (nvm_image_i.options & OPTIONS_NVM_MASK)
				| (state_reg.options & ~OPTIONS_NVM_MASK & OPTIONS_WR_MASK);
		end
		// read stream: a pop shifts the next byte out, a start reloads
		if (rd_pop_i && state_reg.rd_cnt != 2'h0) begin
			state_next.rd_buf = {8'h00, state_reg.rd_buf[23:8]};
			state_next.rd_cnt = state_reg.rd_cnt - 2'h1;
		end
		if (cmd_i.rd_start && !cmd_i.byte_len && mapped) begin
			if (hit_rev) begin
				state_next.rd_buf = {SILICON_REV, BLOCK_COUNT};
				state_next.rd_cnt = 2'h3;
			end else begin
				state_next.rd_buf = {8'h00, hit_scratch ? state_reg.scratch
					: state_reg.options};
				state_next.rd_cnt = 2'h2;
			end
		end
		if (store_all_i) begin
			state_next.save = 1'b1;
			state_next.image.scratch = state_reg.scratch[7:0];
			state_next.image.options = state_reg.options & OPTIONS_NVM_MASK;
		end
		// comparator pin: three stages, accept when last two agree
		state_next.cmp_s1 = bus_detect_cmp_i;
		state_next.cmp_s2 = state_reg.cmp_s1;
		state_next.cmp_s3 = state_reg.cmp_s2;
		if (state_reg.cmp_s2 == state_reg.cmp_s3) begin
			state_next.cmp_stable = state_reg.cmp_s3;
		end
		// auto detect picks from comparator and pin
		if (state_reg.options[AUTO_THR_BIT]) begin
			state_next.thr_1v8 = state_reg.cmp_stable
				| preset_voltage_pin_used_i;
		end else begin
			state_next.thr_1v8 = state_reg.options[FORCED_THR_BIT];
		end
		state_next.meas.conv_en = state_reg.options[CONV_EN_BIT];
		state_next.meas.vout_upd = state_reg.options[CONV_EN_BIT];
		state_next.meas.iout_upd = state_reg.options[CONV_EN_BIT]
			& ~state_reg.options[VONLY_BIT];
		state_next.meas.temp_upd = state_next.meas.iout_upd;
		state_next.meas.fast_vout = state_reg.options[VONLY_BIT];
		case (avg_sel)
			AVG_16: state_next.meas.avg_depth = DEPTH_16;
			AVG_8: state_next.meas.avg_depth = DEPTH_8;
			AVG_32: state_next.meas.avg_depth = DEPTH_32;
			default: state_next.meas.avg_depth = DEPTH_ONE;
		endcase
		state_next.meas.avg_bypass = avg_sel == AVG_BYPASS;
		// invalid flag only without override; no replay
		state_next.inv_set = invalid_seen_i & ~state_reg.options[OVERRIDE_BIT];
		// mask faults present at the answer; set wins over clear
		state_next.fmask = state_reg.fmask & ~fault_unmask_i;
		if (ara_answered_i && state_reg.options[AUTO_ARA_BIT]) begin
			state_next.fmask = state_next.fmask | fault_active_i;
		end
		// stream flags kept in flops, so the pins carry no decode
		state_next.rd_valid = state_next.rd_cnt != 2'h0;
		state_next.rd_last = state_next.rd_cnt == 2'h1;
	end

	// single register stage for the whole bank
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= '0;
			state_reg.scratch <= SCRATCH_RESET;
			state_reg.options <= OPTIONS_RESET;
			state_reg.meas.conv_en <= 1'b1;
			state_reg.meas.vout_upd <= 1'b1;
			state_reg.meas.iout_upd <= 1'b1;
			state_reg.meas.temp_upd <= 1'b1;
			state_reg.meas.avg_depth <= DEPTH_8;
			state_reg.thr_1v8 <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	// outputs straight from the flops
	assign ack_o = state_reg.ack;
	assign nack_o = state_reg.nack;
	assign rd_byte_o = state_reg.rd_buf[7:0];
	assign rd_valid_o = state_reg.rd_valid;
	assign rd_last_o = state_reg.rd_last;
	assign nvm_save_o = state_reg.save;
	assign nvm_image_o = state_reg.image;
	assign thr_1v8_o = state_reg.thr_1v8;
	assign meas_ctl_o = state_reg.meas;
	// override level to the write checkers
	assign write_check_override_o = state_reg.options[OVERRIDE_BIT];
	assign invalid_flag_set_o = state_reg.inv_set;
	assign soft_start_detect_disable_o = state_reg.options[SS_DIS_BIT];
	assign fault_mask_o = state_reg.fmask;

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	// command port, read stream, register bits, store, thresholds, telemetry, averaging, invalid flag and masks
	rev_stream_a: assert property (
		cmd_i.rd_start && !cmd_i.byte_len && hit_rev
		|=> rd_byte_o == BLOCK_COUNT && rd_valid_o && !rd_last_o)
		else $error("revision stream order wrong");
	rev_low_a: assert property (
		state_reg.rd_cnt == 2'h3 && rd_pop_i && !cmd_i.rd_start
		|=> rd_byte_o == SILICON_REV[7:0] && !rd_last_o
		&& state_reg.rd_buf[15:8] == SILICON_REV[15:8])
		else $error("revision low byte not after count");
	rev_readonly_a: assert property (
		cmd_i.wr_word && hit_rev && !nvm_restore_i
		|=> $stable(state_reg.options)
		&& $stable(state_reg.scratch))
		else $error("revision write changed a register");
	scratch_high_a: assert property (
		state_reg.scratch[15:8] == 8'h00)
		else $error("scratch upper byte not zero");
	byte_refused_a: assert property (
		cmd_i.wr_word && cmd_i.byte_len && !nvm_restore_i
		|=> nack_o && $stable(state_reg.scratch) && $stable(state_reg.options))
		else $error("byte write was accepted");
	save_image_a: assert property (
		store_all_i |=> nvm_save_o && nvm_image_o.options[VONLY_BIT] == 1'b0
		&& nvm_image_o.options[OVERRIDE_BIT] == 1'b0
		&& nvm_image_o.scratch == $past(state_reg.scratch[7:0]))
		else $error("saved image wrong");
	forced_thr_a: assert property (
		!state_reg.options[AUTO_THR_BIT]
		|=> thr_1v8_o == $past(state_reg.options[FORCED_THR_BIT]))
		else $error("forced threshold not followed");
	telemetry_hold_a: assert property (
		!state_reg.options[CONV_EN_BIT] |=> !meas_ctl_o.vout_upd
		&& !meas_ctl_o.iout_upd && !meas_ctl_o.temp_upd)
		else $error("telemetry updates with converter off");
	vonly_a: assert property (
		state_reg.options[VONLY_BIT] && state_reg.options[CONV_EN_BIT]
		|=> meas_ctl_o.vout_upd && !meas_ctl_o.iout_upd && meas_ctl_o.fast_vout)
		else $error("voltage-only mode wrong");
	avg_depth_a: assert property (
		avg_sel == AVG_32 ##1 avg_sel == AVG_32
		|-> meas_ctl_o.avg_depth == DEPTH_32)
		else $error("averaging depth wrong");
	invalid_gate_a: assert property (
		invalid_seen_i && state_reg.options[OVERRIDE_BIT] |=> !invalid_flag_set_o)
		else $error("invalid flag under override");
	reserved_a: assert property (
		state_reg.options[15:9] == 7'h00)
		else $error("reserved option bits set");
	ara_mask_a: assert property (
		ara_answered_i && state_reg.options[AUTO_ARA_BIT]
		|=> (fault_mask_o & $past(fault_active_i)) == $past(fault_active_i))
		else $error("active fault not masked");

	byte_read_refused_a: assert property (
		cmd_i.rd_start && cmd_i.byte_len |=> nack_o && !ack_o)
		else $error("byte read was accepted");
	// register contents after host writes
	scratch_write_a: assert property (
		cmd_i.wr_word && !cmd_i.byte_len && hit_scratch && !nvm_restore_i
		|=> state_reg.scratch == {8'h00, $past(cmd_i.wdata[7:0])})
		else $error("scratch write stored wrong value");
	options_write_a: assert property (
		cmd_i.wr_word && !cmd_i.byte_len && hit_options && !nvm_restore_i
		|=> state_reg.options == {7'h00, $past(cmd_i.wdata[8:0])})
		else $error("option write stored wrong value");
	// store and restore; the image stands between saves
	image_stands_a: assert property (
		!store_all_i |=> $stable(nvm_image_o))
		else $error("saved image changed without store");
	restore_keep_a: assert property (
		nvm_restore_i |=> state_reg.options[VONLY_BIT]
		== $past(state_reg.options[VONLY_BIT])
		&& state_reg.options[OVERRIDE_BIT]
		== $past(state_reg.options[OVERRIDE_BIT]))
		else $error("restore touched an unsaved bit");
	// thresholds, telemetry and averaging
	auto_thr_a: assert property (
		state_reg.options[AUTO_THR_BIT]
		|=> thr_1v8_o == ($past(state_reg.cmp_stable)
		| $past(preset_voltage_pin_used_i)))
		else $error("automatic threshold wrong");
	conv_on_a: assert property (
		state_reg.options[CONV_EN_BIT] && !state_reg.options[VONLY_BIT]
		|=> meas_ctl_o.conv_en && meas_ctl_o.vout_upd
		&& meas_ctl_o.iout_upd && meas_ctl_o.temp_upd)
		else $error("telemetry not updating with converter on");
	bypass_a: assert property (
		avg_sel == AVG_BYPASS
		|=> meas_ctl_o.avg_bypass && meas_ctl_o.avg_depth == DEPTH_ONE)
		else $error("averaging bypass not taken");
	// invalid flag and alert masking
	invalid_pass_a: assert property (
		invalid_seen_i && !state_reg.options[OVERRIDE_BIT]
		|=> invalid_flag_set_o)
		else $error("invalid flag lost without override");
	mask_hold_a: assert property (
		!ara_answered_i && fault_unmask_i == '0 |=> $stable(fault_mask_o))
		else $error("fault mask changed without cause");

	// main scenarios seen
	rev_read_c: cover property (cmd_i.rd_start && hit_rev ##1 rd_pop_i [*3]);
	store_c: cover property (store_all_i ##1 nvm_save_o);
	auto_thr_c: cover property (state_reg.options[AUTO_THR_BIT] && thr_1v8_o);
	ara_c: cover property (ara_answered_i && state_reg.options[AUTO_ARA_BIT]);
	bypass_c: cover property (avg_sel == AVG_BYPASS ##1 meas_ctl_o.avg_bypass);
endmodule

// File: test/host_model.sv
// host side of the command port: word writes, word and block reads
`timescale 1ns/100ps
module host_model (
	input wire logic clk_i,
	input wire logic ack_i,
	input wire logic nack_i,
	input wire logic [7:0] rd_byte_i,
	input wire logic rd_last_i,
	output opt_regs_pkg::cmd_t cmd_o,
	output logic rd_pop_o
);
	import opt_regs_pkg::*;
	// idle bus until the first request
	initial begin
		cmd_o = '0;
		rd_pop_o = 1'b0;
	end
	// one-cycle request pulse, answer sampled a cycle later
	task automatic issue(input logic rd, input logic blen,
		input logic [7:0] code, input logic [15:0] data,
		output logic [1:0] resp);
		@(posedge clk_i);
		cmd_o <= {!rd, rd, blen, code, data};
		@(posedge clk_i);
		cmd_o <= '0;
		#1;
		resp = {ack_i, nack_i};
	endtask
	// slow reader: pop is raised a full cycle after each byte shows
	// count byte first on block reads, then low, then high
	task automatic rd_word(input logic [7:0] code, input int n,
		output logic [23:0] q, output logic last);
		logic [1:0] resp;
		q = '0;
		last = 1'b0;
		issue(1'b1, 1'b0, code, 16'h0000, resp);
		for (int i = 0; i < n; i++) begin
			q = {rd_byte_i, q[23:8]};
			last = rd_last_i;
			@(posedge clk_i);
			rd_pop_o <= 1'b1;
			@(posedge clk_i);
			rd_pop_o <= 1'b0;
			#1;
		end
	endtask
endmodule

// File: test/pmbus_option_registers_bench.sv
// self-checking bench for the option register bank
`timescale 1ns/100ps
module pmbus_option_registers_bench;
	import opt_regs_pkg::*;
	logic core_clk_i, rst_n_i, rd_pop_i, store_all_i, nvm_restore_i;
	logic bus_detect_cmp_i, preset_voltage_pin_used_i, invalid_seen_i;
	logic ara_answered_i, ack_o, nack_o, rd_valid_o, rd_last_o;
	logic nvm_save_o, thr_1v8_o, write_check_override_o;
	logic invalid_flag_set_o, soft_start_detect_disable_o, last;
	logic [7:0] fault_active_i, fault_unmask_i, fault_mask_o, rd_byte_o;
	logic [23:0] q;
	logic [1:0] resp;
	logic [5:0] dep [4] = '{6'h10, 6'h01, 6'h08, 6'h20};
	cmd_t cmd_i;
	nvm_image_t nvm_image_i, nvm_image_o;
	meas_ctl_t meas_ctl_o;
	int mismatches = 0;
	int n_compared = 0;
	// revision value is arbitrary, a later silicon step
	pmbus_option_registers #(.SILICON_REV(16'h0102), .FAULTS(8)) uut (
		.core_clk_i, .rst_n_i, .cmd_i, .rd_pop_i, .store_all_i,
		.nvm_restore_i, .nvm_image_i, .bus_detect_cmp_i,
		.preset_voltage_pin_used_i, .invalid_seen_i, .ara_answered_i,
		.fault_active_i, .fault_unmask_i, .ack_o, .nack_o, .rd_byte_o,
		.rd_valid_o, .rd_last_o, .nvm_save_o, .nvm_image_o, .thr_1v8_o,
		.meas_ctl_o, .write_check_override_o, .invalid_flag_set_o,
		.soft_start_detect_disable_o, .fault_mask_o);
	host_model host (.clk_i(core_clk_i), .ack_i(ack_o), .nack_i(nack_o),
		.rd_byte_i(rd_byte_o), .rd_last_i(rd_last_o), .cmd_o(cmd_i),
		.rd_pop_o(rd_pop_i));
	// 40 MHz clock
	initial begin
		core_clk_i = 1'b0;
		forever #12.5 core_clk_i = ~core_clk_i;
	end
	task automatic chk(input string nm, input logic [23:0] e,
		input logic [23:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] c, input logic [15:0] d,
		input logic blen, input logic [1:0] er);
		host.issue(1'b0, blen, c, d, resp);
		chk("write answer", 24'(er), 24'(resp));
	endtask
	task automatic rd(input logic [7:0] c, input logic [15:0] e);
		host.rd_word(c, 2, q, last);
		chk("read word", 24'(e), 24'(q[23:8]));
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	task automatic finish_test;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// watchdog: the sequence needs well under 2000 cycles
	initial begin
		#125000;
		mismatches++;
		finish_test();
	end
	initial begin
		rst_n_i = 1'b0;
		{store_all_i, nvm_restore_i, bus_detect_cmp_i} = '0;
		{preset_voltage_pin_used_i, invalid_seen_i, ara_answered_i} = '0;
		{fault_active_i, fault_unmask_i, nvm_image_i} = '0;
		repeat (5) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		settle(1);
		rd(CODE_SCRATCH, 16'h0000);
		rd(CODE_OPTIONS, 16'h00c7);
		chk("meas ctl", 24'h000f08, 24'(meas_ctl_o));
		// revision stream, then a write that must not land
		for (int k = 0; k < 2; k++) begin
			host.rd_word(CODE_REV, 3, q, last);
			chk("revision stream", 24'h010202, q);
			chk("last flag", 24'h1, 24'(last));
			chk("valid after", 24'h0, 24'(rd_valid_o));
			if (k == 0) wr(CODE_REV, 16'hffff, 1'b0, 2'b10);
		end
		wr(CODE_SCRATCH, 16'hffa5, 1'b0, 2'b10);
		wr(CODE_SCRATCH, 16'h0011, 1'b1, 2'b01);
		host.issue(1'b1, 1'b1, CODE_SCRATCH, 16'h0000, resp);
		chk("byte read answer", 24'h1, 24'(resp));
		chk("byte read stream", 24'h0, 24'(rd_valid_o));
		wr(8'h11, 16'h0011, 1'b0, 2'b01);
		rd(CODE_SCRATCH, 16'h00a5);
		wr(CODE_OPTIONS, 16'hffff, 1'b0, 2'b10);
		rd(CODE_OPTIONS, 16'h01ff);
		// store with override and voltage-only set
		@(posedge core_clk_i);
		store_all_i <= 1'b1;
		invalid_seen_i <= 1'b1;
		@(posedge core_clk_i);
		{store_all_i, invalid_seen_i} <= '0;
		#1;
		chk("save pulse", 24'h1, 24'(nvm_save_o));
		chk("image", 24'ha501e7, 24'(nvm_image_o));
		chk("override", 24'h1, 24'(write_check_override_o));
		chk("invalid flag", 24'h0, 24'(invalid_flag_set_o));
		chk("ss disable", 24'h1, 24'(soft_start_detect_disable_o));
		// restore keeps the two unsaved bits as they stand
		@(posedge core_clk_i);
		nvm_image_i <= {8'h3c, 16'h0007};
		nvm_restore_i <= 1'b1;
		@(posedge core_clk_i);
		nvm_restore_i <= 1'b0;
		rd(CODE_SCRATCH, 16'h003c);
		rd(CODE_OPTIONS, 16'h001f);
		wr(CODE_OPTIONS, 16'h0007, 1'b0, 2'b10);
		settle(2);
		chk("flag on exit", 24'h0, 24'(invalid_flag_set_o));
		@(posedge core_clk_i);
		invalid_seen_i <= 1'b1;
		@(posedge core_clk_i);
		invalid_seen_i <= 1'b0;
		#1;
		chk("invalid flag", 24'h1, 24'(invalid_flag_set_o));
		// every averaging code
		for (int a = 0; a < 4; a++) begin
			wr(CODE_OPTIONS, 16'(32'h4 | (a << 5)), 1'b0, 2'b10);
			settle(1);
			chk("avg", 24'({5'h1e, a == 1, dep[a]}), 24'(meas_ctl_o));
		end
		wr(CODE_OPTIONS, 16'h004c, 1'b0, 2'b10);
		settle(1);
		chk("vonly", 24'h000c88, 24'(meas_ctl_o));
		wr(CODE_OPTIONS, 16'h0040, 1'b0, 2'b10);
		settle(1);
		chk("conv off", 24'h000008, 24'(meas_ctl_o));
		// all threshold combinations; comparator needs its sync delay
		for (int i = 0; i < 16; i++) begin
			@(posedge core_clk_i);
			{bus_detect_cmp_i, preset_voltage_pin_used_i} <= 2'(i);
			wr(CODE_OPTIONS, 16'(32'h44 | (i >> 2)), 1'b0, 2'b10);
			settle(6);
			chk("thr", 24'(i[3] ? |i[1:0] : i[2]), 24'(thr_1v8_o));
		end
		// alert response masks the faults then active
		wr(CODE_OPTIONS, 16'h0087, 1'b0, 2'b10);
		@(posedge core_clk_i);
		fault_active_i <= 8'h5a;
		ara_answered_i <= 1'b1;
		@(posedge core_clk_i);
		ara_answered_i <= 1'b0;
		fault_unmask_i <= 8'h0a;
		#1;
		chk("fault mask", 24'h5a, 24'(fault_mask_o));
		@(posedge core_clk_i);
		fault_unmask_i <= 8'h00;
		#1;
		chk("fault unmask", 24'h50, 24'(fault_mask_o));
		// mid-run reset brings back the defaults
		@(posedge core_clk_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		settle(1);
		chk("mask reset", 24'h0, 24'(fault_mask_o));
		rd(CODE_SCRATCH, 16'h0000);
		rd(CODE_OPTIONS, 16'h00c7);
		chk("meas reset", 24'h000f08, 24'(meas_ctl_o));
		finish_test();
	end
endmodule
